// ---- rtl/fpc_top.sv ----
`timescale 1ns/1ps
`include "fpc_consts.svh"

// Overview of operation
// [R1] Group 11111 is the idle symbol, sent and recognised between frames.
// [R2] Group 11000 after idle gives nibble 0101; elsewhere it raises error.
// [R3] Group 10001 after 11000 gives nibble 0101; otherwise raises error.
// [R4] Group 01101 drops carrier when 00111 follows; otherwise raises error.
// [R5] Group 00111 drops carrier when it follows 01101; otherwise raises error.
// [R6] 00100 is transmit error; 00000-00011, 00101 invalid; receiving them errs.
// [R7] Idle or delimiter groups inside frame data are invalid, with error.
// [R8] Transmit scrambler seed derives from the configured PHY address.
// [R9] Scrambled serial bits are NRZI encoded, then turned into MLT-3.
// [R10] MLT-3 output changes level on each one, holds level on each zero.
// [R11] Receive decodes MLT-3 to NRZI, then NRZI to NRZ for descrambling.
// [R12] Descrambled bits are aligned to five-bit groups and mapped to nibbles.
// [R13] Descrambler locks on received idle; traffic disabled until locked.
// [R14] After lock, sync is checked; on loss, lock is reacquired from idle.
// [R15] Receive symbols are sampled at 125 MHz on the recovered clock.
// [R16] Delimiter pair becomes 0101 0101; frame ends on T R or two idles.
// [R17] Non-idle after idle without valid start: error, nibble 1110 until idles.
// [R18] Scrambling uses the 11-bit free-running additive stream cipher.
module fpc_top
	import fpc_pkg::*;
#(
	parameter int SYNC_TIMEOUT_CYC =
		`FPC_SYNC_TIMEOUT_NS / `FPC_CLK_PERIOD_NS
)(
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	// Configuration
	input  wire logic [4:0] i_phy_addr,
	// Transmit nibbles from the MAC
	input  wire logic       i_tx_en,
	input  wire logic       i_tx_er,
	input  wire logic [3:0] i_txd,
	output logic            o_tx_ready,
	// Line side
	output fpc_mlt3_s       o_mlt3,
	input  wire fpc_mlt3_s  i_rx_mlt3,
	// Receive nibbles to the MAC
	output fpc_rx_s         o_rx,
	output logic            o_rx_stb,
	output logic            o_locked
);

////////////////////////////////////////////////////////////////////////////////
// Transmit coding
fpc_tx_state_e tx_state;
fpc_tx_state_e next_tx_state;
logic [2:0]    tx_cnt;
fpc_code_t     tx_sh;
fpc_code_t     next_tx_sym;
logic [10:0]   tx_lfsr;
logic          tx_nrzi;
logic [1:0]    tx_phase;
wire logic     tx_load  = (tx_cnt == 3'h4);
wire logic     tx_ks    = tx_lfsr[10] ^ tx_lfsr[8];
wire logic     tx_bit   = tx_sh[4] ^ tx_ks;                  // R18
wire logic     tx_go    = i_tx_en && o_locked;               // R13
wire fpc_code_t tx_data = i_tx_er ? `FPC_SYM_H : fpc_enc(i_txd); // R6

assign o_tx_ready = tx_load && i_tx_en && (tx_state != FPC_TX_R) &&
	(o_locked || (tx_state != FPC_TX_IDLE));

always_comb begin
	next_tx_state = tx_state;
	next_tx_sym   = `FPC_SYM_I;                              // R1
	case (tx_state)
		FPC_TX_IDLE: begin
			if (tx_go) begin
				next_tx_sym   = `FPC_SYM_J;
				next_tx_state = FPC_TX_K;
			end
		end
		FPC_TX_K: begin
			next_tx_sym   = `FPC_SYM_K;
			next_tx_state = FPC_TX_DATA;
		end
		FPC_TX_DATA: begin
			if (i_tx_en) begin
				next_tx_sym = tx_data;
			end else begin
				next_tx_sym   = `FPC_SYM_T;
				next_tx_state = FPC_TX_R;
			end
		end
		FPC_TX_R: begin
			next_tx_sym   = `FPC_SYM_R;
			next_tx_state = FPC_TX_IDLE;
		end
		default: next_tx_state = FPC_TX_IDLE;
	endcase
end

always_ff @(posedge i_clk) begin
	if (!i_rst_n) begin
		tx_state <= FPC_TX_IDLE;
		tx_cnt   <= 3'h0;
		tx_sh    <= `FPC_SYM_I;
		tx_lfsr  <= {`FPC_SEED_HI, i_phy_addr};              // R8
		tx_nrzi  <= 1'b0;
		tx_phase <= 2'h0;
	end else begin
		tx_cnt  <= tx_load ? 3'h0 : tx_cnt + 3'h1;
		tx_lfsr <= {tx_lfsr[9:0], tx_ks};                    // R18
		tx_nrzi <= tx_nrzi ^ tx_bit;                         // R9
		tx_phase <= tx_phase + {1'b0, tx_bit};               // R10
		if (tx_load) begin
			tx_state <= next_tx_state;
			tx_sh    <= next_tx_sym;
		end else begin
			tx_sh <= {tx_sh[3:0], 1'b0};
		end
	end
end

assign o_mlt3 = '{pos: (tx_phase == 2'h1), neg: (tx_phase == 2'h3)};

////////////////////////////////////////////////////////////////////////////////
// Receive line decoding and descrambling
fpc_mlt3_s   rx_lvl;
logic        rx_nrzi;
logic        rx_nrzi_d;
logic [10:0] rx_lfsr;
logic [5:0]  rx_ones;
logic [16:0] sync_tmr;
wire logic   rx_nrz = rx_nrzi ^ rx_nrzi_d;                   // R11
wire logic   rx_ks  = rx_lfsr[10] ^ rx_lfsr[8];
wire logic   rx_d   = rx_nrz ^ rx_ks;                        // R18
wire logic   sync_lost = o_locked &&
	(sync_tmr >= 17'(SYNC_TIMEOUT_CYC - 1));
wire logic   rx_live   = o_locked && !sync_lost;              // R14

always_ff @(posedge i_clk) begin
	if (!i_rst_n) begin
		rx_lvl    <= '0;
		rx_nrzi   <= 1'b0;
		rx_nrzi_d <= 1'b0;
		rx_lfsr   <= 11'h000;
		rx_ones   <= 6'h00;
		o_locked  <= 1'b0;
		sync_tmr  <= 17'h0_0000;
	end else begin
		rx_lvl    <= i_rx_mlt3;                              // R15
		rx_nrzi   <= rx_nrzi ^ (rx_lvl != i_rx_mlt3);        // R11
		rx_nrzi_d <= rx_nrzi;
		rx_lfsr   <= {rx_lfsr[9:0], o_locked ? rx_ks : ~rx_nrz}; // R13
		rx_ones   <= !rx_d ? 6'h00 :
			(rx_ones == 6'h3F) ? rx_ones : rx_ones + 6'h01;
		if (sync_lost) begin
			o_locked <= 1'b0;                                // R14
		end else if (!o_locked && rx_ones >= `FPC_LOCK_RUN) begin
			o_locked <= 1'b1;                                // R13
		end
		if (!o_locked || rx_ones >= `FPC_LOCK_RUN) begin
			sync_tmr <= 17'h0_0000;                          // R14
		end else begin
			sync_tmr <= sync_tmr + 17'h0_0001;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Group alignment and symbol decoding
fpc_rx_state_e rx_state;
fpc_rx_state_e next_rx_state;
fpc_rx_s       next_rx;
logic [9:0]    rx_sh;
logic [2:0]    rx_cnt;
wire logic     rx_tick = (rx_cnt == 3'h4);
wire fpc_code_t rx_g   = rx_sh[4:0];
wire fpc_code_t rx_pv  = rx_sh[9:5];
wire logic [4:0] rx_dc = fpc_dec(rx_g);
wire logic     two_idle = (rx_g == `FPC_SYM_I) && (rx_pv == `FPC_SYM_I);
wire logic     realign  = (rx_state == FPC_RX_IDLE) && !rx_d &&
	(rx_ones >= `FPC_IDLE2_RUN);

always_comb begin
	next_rx_state = rx_state;
	next_rx       = '{crs: 1'b1, dv: 1'b0, er: 1'b0, nib: `FPC_NIB_ZERO};
	case (rx_state)
		FPC_RX_IDLE: begin
			next_rx.crs = 1'b0;
			if (rx_g == `FPC_SYM_J) begin
				next_rx       = '{1'b1, 1'b1, 1'b0, `FPC_NIB_PRE}; // R2
				next_rx_state = FPC_RX_SSD;
			end else if (rx_g != `FPC_SYM_I) begin
				next_rx       = '{1'b1, 1'b0, 1'b1, `FPC_NIB_BAD}; // R17
				next_rx_state = FPC_RX_BAD;
			end
		end
		FPC_RX_SSD: begin
			if (rx_g == `FPC_SYM_K) begin
				next_rx       = '{1'b1, 1'b1, 1'b0, `FPC_NIB_PRE}; // R3
				next_rx_state = FPC_RX_FRAME;
			end else begin
				next_rx       = '{1'b1, 1'b0, 1'b1, `FPC_NIB_BAD}; // R3
				next_rx_state = FPC_RX_BAD;
			end
		end
		FPC_RX_FRAME: begin
			if (rx_dc[4]) begin
				next_rx = '{1'b1, 1'b1, 1'b0, rx_dc[3:0]};   // R12
			end else if (rx_g == `FPC_SYM_T) begin
				next_rx_state = FPC_RX_ESD;                  // R4
			end else if (two_idle) begin
				next_rx       = '{1'b0, 1'b0, 1'b0, `FPC_NIB_ZERO}; // R16
				next_rx_state = FPC_RX_IDLE;
			end else begin
				next_rx = '{1'b1, 1'b1, 1'b1, `FPC_NIB_ZERO}; // R6 R7
			end
		end
		FPC_RX_ESD: begin
			if (rx_g == `FPC_SYM_R) begin
				next_rx       = '{1'b0, 1'b0, 1'b0, `FPC_NIB_ZERO}; // R5
				next_rx_state = FPC_RX_IDLE;
			end else begin
				next_rx       = '{1'b1, 1'b1, 1'b1, `FPC_NIB_ZERO}; // R4
				next_rx_state = FPC_RX_FRAME;
			end
		end
		FPC_RX_BAD: begin
			next_rx.er  = 1'b1;
			next_rx.nib = `FPC_NIB_BAD;                      // R17
			if (two_idle) begin
				next_rx       = '{1'b0, 1'b0, 1'b0, `FPC_NIB_ZERO};
				next_rx_state = FPC_RX_IDLE;
			end
		end
		default: next_rx_state = FPC_RX_IDLE;
	endcase
end

always_ff @(posedge i_clk) begin
	if (!i_rst_n) begin
		rx_state <= FPC_RX_IDLE;
		rx_sh    <= 10'h3FF;
		rx_cnt   <= 3'h0;
		o_rx     <= '0;
		o_rx_stb <= 1'b0;
	end else begin
		rx_sh    <= {rx_sh[8:0], rx_d};                      // R12
		rx_cnt   <= realign ? 3'h2 : (rx_tick ? 3'h0 : rx_cnt + 3'h1);
		o_rx_stb <= rx_tick && rx_live;
		if (!rx_live) begin
			rx_state <= FPC_RX_IDLE;                         // R13
			o_rx     <= '0;
		end else if (rx_tick) begin
			rx_state <= next_rx_state;
			o_rx     <= next_rx;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Checks
sequence s_ssd_seen;
	rx_tick && rx_live && rx_state == FPC_RX_IDLE && rx_g == `FPC_SYM_J;
endsequence
sequence s_pre_out;
	o_rx_stb && o_rx.dv && o_rx.nib == `FPC_NIB_PRE;
endsequence

property p_ssd_pre;
	@(posedge i_clk) disable iff (!i_rst_n) s_ssd_seen |=> s_pre_out;
endproperty
a_ssd_pre: assert property (p_ssd_pre) // R2
	else $error("Start group not mapped to preamble");

property p_idle_unlocked;
	@(posedge i_clk) disable iff (!i_rst_n)
		tx_load && tx_state == FPC_TX_IDLE && !o_locked
		|=> tx_sh == `FPC_SYM_I;
endproperty
a_idle_unlocked: assert property (p_idle_unlocked) // R1
	else $error("Non-idle sent while unlocked");

property p_mlt3_one;
	@(posedge i_clk) disable iff (!i_rst_n)
		tx_bit |=> o_mlt3 != $past(o_mlt3);
endproperty
a_mlt3_one: assert property (p_mlt3_one) // R10
	else $error("Level held on a one");

property p_mlt3_zero;
	@(posedge i_clk) disable iff (!i_rst_n) !tx_bit |=> $stable(o_mlt3);
endproperty
a_mlt3_zero: assert property (p_mlt3_zero) // R10
	else $error("Level changed on a zero");

property p_nrzi;
	@(posedge i_clk) disable iff (!i_rst_n)
		tx_bit |=> tx_nrzi != $past(tx_nrzi);
endproperty
a_nrzi: assert property (p_nrzi) // R9
	else $error("NRZI did not toggle");

property p_bad_nib;
	@(posedge i_clk) disable iff (!i_rst_n)
		rx_tick && rx_live && rx_state == FPC_RX_BAD && !two_idle
		|=> o_rx.er && o_rx.nib == `FPC_NIB_BAD && o_rx.crs;
endproperty
a_bad_nib: assert property (p_bad_nib) // R17
	else $error("Bad start not reported");

property p_invalid;
	@(posedge i_clk) disable iff (!i_rst_n)
		rx_tick && rx_live && rx_state == FPC_RX_FRAME &&
		rx_g inside {`FPC_SYM_H, 5'h00, 5'h05, `FPC_SYM_J, `FPC_SYM_R}
		|=> o_rx.er;
endproperty
a_invalid: assert property (p_invalid) // R6
	else $error("Invalid group not flagged");

property p_esd;
	@(posedge i_clk) disable iff (!i_rst_n)
		rx_tick && rx_live && rx_state == FPC_RX_ESD &&
		rx_g == `FPC_SYM_R |=> !o_rx.crs ##1 rx_state == FPC_RX_IDLE;
endproperty
a_esd: assert property (p_esd) // R5
	else $error("Carrier not dropped on end pair");

property p_unlocked_rx;
	@(posedge i_clk) disable iff (!i_rst_n)
		!o_locked |=> rx_state == FPC_RX_IDLE && !o_rx.dv;
endproperty
a_unlocked_rx: assert property (p_unlocked_rx) // R13
	else $error("Reception while unlocked");

property p_sync_loss;
	@(posedge i_clk) disable iff (!i_rst_n) sync_lost |=> !o_locked;
endproperty
a_sync_loss: assert property (p_sync_loss) // R14
	else $error("Lock kept after sync loss");

endmodule

// ---- rtl/fpc_consts.svh ----
`ifndef FPC_CONSTS_SVH
`define FPC_CONSTS_SVH

// Control code groups
`define FPC_SYM_I      5'h1F
`define FPC_SYM_J      5'h18
`define FPC_SYM_K      5'h11
`define FPC_SYM_T      5'h0D
`define FPC_SYM_R      5'h07
`define FPC_SYM_H      5'h04

// Nibbles presented to the MAC
`define FPC_NIB_PRE    4'h5
`define FPC_NIB_BAD    4'hE
`define FPC_NIB_ZERO   4'h0

// Descrambler run lengths, in bits
`define FPC_LOCK_RUN   6'h1E
`define FPC_IDLE2_RUN  6'h0A

// Timing
`define FPC_CLK_PERIOD_NS   8
`define FPC_SYNC_TIMEOUT_NS 722000

// Scrambler seed padding above the address
`define FPC_SEED_HI    6'h20

`endif

// ---- rtl/fpc_pkg.sv ----
package fpc_pkg;

	typedef enum logic [4:0] {
		FPC_RX_IDLE  = 5'b00001,
		FPC_RX_SSD   = 5'b00010,
		FPC_RX_FRAME = 5'b00100,
		FPC_RX_ESD   = 5'b01000,
		FPC_RX_BAD   = 5'b10000
	} fpc_rx_state_e;

	typedef enum logic [3:0] {
		FPC_TX_IDLE = 4'b0001,
		FPC_TX_K    = 4'b0010,
		FPC_TX_DATA = 4'b0100,
		FPC_TX_R    = 4'b1000
	} fpc_tx_state_e;

	typedef struct packed {
		logic       crs;
		logic       dv;
		logic       er;
		logic [3:0] nib;
	} fpc_rx_s;

	typedef struct packed {
		logic pos;
		logic neg;
	} fpc_mlt3_s;

	typedef logic [4:0] fpc_code_t;

	function automatic fpc_code_t fpc_enc(input logic [3:0] n);
		case (n)
			4'h0: fpc_enc = 5'h1E;
			4'h1: fpc_enc = 5'h09;
			4'h2: fpc_enc = 5'h14;
			4'h3: fpc_enc = 5'h15;
			4'h4: fpc_enc = 5'h0A;
			4'h5: fpc_enc = 5'h0B;
			4'h6: fpc_enc = 5'h0E;
			4'h7: fpc_enc = 5'h0F;
			4'h8: fpc_enc = 5'h12;
			4'h9: fpc_enc = 5'h13;
			4'hA: fpc_enc = 5'h16;
			4'hB: fpc_enc = 5'h17;
			4'hC: fpc_enc = 5'h1A;
			4'hD: fpc_enc = 5'h1B;
			4'hE: fpc_enc = 5'h1C;
			default: fpc_enc = 5'h1D;
		endcase
	endfunction

	// Returns {valid, nibble}
	function automatic logic [4:0] fpc_dec(input fpc_code_t c);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < 16; i++) begin
			if (fpc_enc(4'(i)) == c) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

endpackage

// ---- tb/fpc_mac_model.sv ----
`timescale 1ns/1ps
module fpc_mac_model
	import fpc_pkg::*;
(
	// Clock
	input  wire logic    i_clk,
	// Transmit nibbles
	input  wire logic    i_tx_ready,
	output logic         o_tx_en,
	output logic         o_tx_er,
	output logic [3:0]   o_txd,
	// Receive nibbles
	input  wire fpc_rx_s i_rx,
	input  wire logic    i_rx_stb
);
	logic [4:0] txq[$];
	fpc_rx_s    rxq[$];
	logic       taken;

	initial begin
		o_tx_en = 1'b0;
		o_tx_er = 1'b0;
		o_txd = 4'h0;
		taken = 1'b0;
	end

	always @(posedge i_clk) begin
		if (i_tx_ready && o_tx_en) begin
			taken = 1'b1;
		end
	end

	// Next nibble only after the current one was taken
	always @(negedge i_clk) begin
		if (taken || !o_tx_en) begin
			taken = 1'b0;
			if (txq.size() > 0) begin
				{o_tx_er, o_txd} = txq.pop_front();
				o_tx_en = 1'b1;
			end else begin
				o_tx_en = 1'b0;
				o_tx_er = 1'b0;
			end
		end
		if (i_rx_stb && (i_rx.crs || i_rx.er)) begin
			rxq.push_back(i_rx);
		end
	end
endmodule

// ---- tb/fpc_top_bench.sv ----
`timescale 1ns/1ps
module fpc_top_bench
	import fpc_pkg::*;
;
	typedef struct packed {
		logic       er;
		logic [3:0] nib;
		logic       exp_er;
		logic [3:0] exp_nib;
	} fpc_row_s;

	logic        i_clk;
	logic        i_rst_n;
	logic [4:0]  phy_addr;
	logic        cut;
	logic        tx_en;
	logic        tx_er;
	logic [3:0]  txd;
	logic        tx_ready;
	logic        locked;
	logic        rx_stb;
	fpc_mlt3_s   line_tx;
	fpc_mlt3_s   line_rx;
	fpc_rx_s     rx;
	fpc_row_s    rows[18];
	logic [79:0] pat_a;
	logic [79:0] pat_b;
	logic [1:0]  prev_lvl;
	logic        last_pos;
	logic        seen;
	int          error_cnt;
	int          checks;

	////////////////////////////////////////////////////////////////////////
	// Loopback line, broken on demand
	assign line_rx = cut ? 2'h0 : line_tx;

	fpc_top #(.SYNC_TIMEOUT_CYC(200)) dut (
		.i_clk      (i_clk),
		.i_rst_n    (i_rst_n),
		.i_phy_addr (phy_addr),
		.i_tx_en    (tx_en),
		.i_tx_er    (tx_er),
		.i_txd      (txd),
		.o_tx_ready (tx_ready),
		.o_mlt3     (line_tx),
		.i_rx_mlt3  (line_rx),
		.o_rx       (rx),
		.o_rx_stb   (rx_stb),
		.o_locked   (locked)
	);

	fpc_mac_model mac (
		.i_clk      (i_clk),
		.i_tx_ready (tx_ready),
		.o_tx_en    (tx_en),
		.o_tx_er    (tx_er),
		.o_txd      (txd),
		.i_rx       (rx),
		.i_rx_stb   (rx_stb)
	);

	always #4 i_clk = ~i_clk;

	////////////////////////////////////////////////////////////////////////
	// Compare tasks and closing
	task automatic chk_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_word(input fpc_rx_s got, input fpc_rx_s exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic wait_lock(input logic val, input int bound);
		int i;
		i = 0;
		while (locked !== val && i < bound) begin
			@(negedge i_clk);
			i++;
		end
		chk_bit(locked, val);
		if (locked !== val) complete_run();
	endtask

	task automatic grab(output logic [79:0] pat);
		i_rst_n = 1'b0;
		repeat (2) @(negedge i_clk);
		chk_bit(|{line_tx, rx, rx_stb, locked, tx_ready}, 1'b0);
		i_rst_n = 1'b1;
		for (int i = 0; i < 40; i++) begin
			@(negedge i_clk);
			pat = {pat[77:0], line_tx};
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Monitors on traffic gating and line levels
	always @(negedge i_clk) begin
		if (i_rst_n && (tx_ready || rx_stb)) begin
			chk_bit(locked, 1'b1);
		end
		if (!i_rst_n) begin
			seen = 1'b0;
		end else if (line_tx !== prev_lvl) begin
			chk_bit(!(&line_tx) && (line_tx == 2'h0 || prev_lvl == 2'h0
				&& (!seen || line_tx[1] != last_pos)), 1'b1);
		end
		if (line_tx[1] ^ line_tx[0]) begin
			last_pos = line_tx[1];
			seen = 1'b1;
		end
		prev_lvl = line_tx;
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		int n;
		i_clk = 1'b0;
		i_rst_n = 1'b0;
		phy_addr = 5'h03;
		cut = 1'b0;
		seen = 1'b0;
		error_cnt = 0;
		checks = 0;
		repeat (6) @(negedge i_clk);
		i_rst_n = 1'b1;
		wait_lock(1'b1, 3000);
		$display("test lock done");
		for (int i = 0; i < 16; i++) begin
			rows[i] = {1'b0, 4'(i), 1'b0, 4'(i)};
		end
		rows[16] = {1'b1, 4'h3, 1'b1, 4'h0};
		rows[17] = {1'b0, 4'hA, 1'b0, 4'hA};
		mac.txq.push_back(5'h05);
		mac.txq.push_back(5'h05);
		foreach (rows[i]) mac.txq.push_back({rows[i].er, rows[i].nib});
		n = 0;
		while (mac.rxq.size() < 21 && n < 3000) begin
			@(negedge i_clk);
			n++;
		end
		chk_bit(n < 3000, 1'b1);
		if (n >= 3000) complete_run();
		chk_word(mac.rxq.pop_front(), 7'h65);
		chk_word(mac.rxq.pop_front(), 7'h65);
		foreach (rows[i]) begin
			chk_word(mac.rxq.pop_front(),
				{2'b11, rows[i].exp_er, rows[i].exp_nib});
		end
		chk_word(mac.rxq.pop_front(), 7'h40);
		repeat (12) @(negedge i_clk);
		chk_bit(rx.crs, 1'b0);
		$display("test frame done");
		cut = 1'b1;
		wait_lock(1'b0, 1000);
		cut = 1'b0;
		wait_lock(1'b1, 3000);
		$display("test relock done");
		grab(pat_a);
		phy_addr = 5'h1C;
		grab(pat_b);
		chk_bit(pat_a !== pat_b, 1'b1);
		wait_lock(1'b1, 3000);
		$display("test seed done");
		complete_run();
	end
endmodule
